// File: verilog/spi_port_pkg.sv
package spi_port_pkg;

  localparam int          WORD_W_DEF       = 16;
  localparam int          FIFO_DEPTH_DEF   = 8;
  localparam int          DIV_W            = 8;
  localparam int          CNT_W            = DIV_W + 1;
  localparam int          CLK_PERIOD_NS    = 40;
  localparam logic [1:0]  STOP_SAMPLE_RISE = 2'h2;
  localparam logic [1:0]  STOP_SAMPLE_FALL = 2'h3;
  localparam logic [7:0]  SLAVE_DIV_VALUE  = 8'h01;
  localparam logic        PIN_IDLE_RST     = 1'h1;
  localparam logic        DATA_OUT_RST     = 1'h0;

  typedef struct packed {
    logic [1:0]       clock_stop_select;
    logic             tx_clock_polarity;
    logic             tx_clock_direction;
    logic             rx_clock_direction;
    logic             tx_frame_direction;
    logic             rx_frame_direction;
    logic             tx_frame_polarity;
    logic             rx_frame_polarity;
    logic             gen_clock_source_select;
    logic [DIV_W-1:0] clock_divide_value;
  } port_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LEAD, ST_LOW, ST_HIGH, ST_LAG, ST_SLAVE
  } xfer_state_t;

  // cycles of one serial clock phase for a divide value
  function automatic logic [CNT_W-1:0] phase_len(
    input logic [DIV_W-1:0] div,
    input logic             high
  );
    logic [CNT_W-1:0] d;
    d = {1'h0, div};
    if (div[0]) begin
      return CNT_W'((d + 1'h1) >> 1);
    end else if (div == '0) begin
      return CNT_W'(1);
    end else if (high) begin
      return CNT_W'((d >> 1) + 1'h1);
    end
    return CNT_W'(d >> 1);
  endfunction : phase_len

endpackage : spi_port_pkg

// File: verilog/word_fifo.sv
`timescale 1ns/1ns
module word_fifo
  import spi_port_pkg::*;
#(
  parameter int WIDTH = WORD_W_DEF,
  parameter int DEPTH = FIFO_DEPTH_DEF
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push_w;
  logic             pop_w;
  logic             in_ready_r;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'h1);
  endfunction : ptr_inc

  assign push_w    = in_valid && in_ready_r;
  assign pop_w     = out_ready && out_valid;
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign in_ready  = in_ready_r;
  assign count_nxt = count_r + (AW+1)'(push_w) - (AW+1)'(pop_w);

  always_ff @(posedge clk) begin
    if (ce && push_w) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      count_r    <= '0;
      in_ready_r <= 1'h0;
    end else if (ce) begin
      if (push_w) wr_ptr_r <= ptr_inc(wr_ptr_r);
      if (pop_w) rd_ptr_r <= ptr_inc(rd_ptr_r);
      count_r    <= count_nxt;
      in_ready_r <= (count_nxt != (AW+1)'(DEPTH));
    end
  end

endmodule : word_fifo

// File: verilog/spi_clock_stop_port.sv
// Notes on behaviour
// - master clock period is one plus divide value, in CPU cycles, or two when divide value is zero.
// - low phase is half period, or half divide value when even and nonzero.
// - high phase is half period, or half divide value plus one when even.
// - master drives the inverted internal frame as active-low slave enable.
// - slave inverts the active-low enable on its frame pins before use.
// - mode 10b: sample on rising clock edge, change after falling edge.
// - mode 11b: sample on falling clock edge, change after rising edge.
// - enable leads first falling edge by high phase (10b) or period (11b).
// - enable lags last rising edge by period (10b) or high phase (11b).
// - master 10b releases data one high phase after the last rising edge.
// - slave releases data pin once incoming enable returns high.
// - slave drives the first data bit as soon as enable goes low.
`timescale 1ns/1ns
module spi_clock_stop_port
  import spi_port_pkg::*;
#(
  parameter int WORD_W     = WORD_W_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire port_cfg_t         cfg,
  input  wire logic [WORD_W-1:0] tx_word_data,
  input  wire logic              tx_word_valid,
  output logic                   tx_word_ready,
  output logic [WORD_W-1:0]      rx_word_data,
  output logic                   rx_word_valid,
  input  wire logic              tx_serial_clock_pin_in,
  output logic                   tx_serial_clock_pin_out,
  output logic                   tx_serial_clock_pin_oe,
  input  wire logic              tx_frame_pin_in,
  output logic                   tx_frame_pin_out,
  output logic                   tx_frame_pin_oe,
  input  wire logic              rx_frame_pin_in,
  output logic                   tx_data_pin_out,
  output logic                   tx_data_pin_oe,
  input  wire logic              rx_data_pin,
  output logic                   busy,
  output logic                   cfg_error
);
  localparam int SC_W = $clog2(WORD_W + 1);
  localparam logic [SC_W-1:0] BITS_N    = SC_W'(WORD_W);
  localparam logic [SC_W-1:0] BITS_LAST = SC_W'(WORD_W - 1);

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode

  logic             master_w;
  logic             slave_w;
  logic             mode_fall_w;
  logic             stop_on_w;
  logic [CNT_W-1:0] lo_w;
  logic [CNT_W-1:0] hi_w;
  logic [CNT_W-1:0] per_w;
  logic [CNT_W-1:0] lead_w;
  logic [CNT_W-1:0] lag_w;

  assign master_w = cfg.tx_clock_direction && cfg.tx_frame_direction
                    && !cfg.rx_clock_direction && !cfg.rx_frame_direction;
  assign slave_w = !cfg.tx_clock_direction && !cfg.tx_frame_direction
                   && !cfg.rx_clock_direction && !cfg.rx_frame_direction;
  assign mode_fall_w = (cfg.clock_stop_select == STOP_SAMPLE_FALL);
  assign stop_on_w   = cfg.clock_stop_select[1];
  assign lo_w   = phase_len(cfg.clock_divide_value, 1'h0);
  assign hi_w   = phase_len(cfg.clock_divide_value, 1'h1);
  // period is the sum of both phases
  assign per_w  = CNT_W'(lo_w + hi_w);
  // enable lead before first falling edge
  assign lead_w = mode_fall_w ? per_w : hi_w;
  // enable lag after last rising edge
  assign lag_w  = mode_fall_w ? hi_w : per_w;

  ////////////////////////////////////////////////////////////////////////////
  // state and counters

  xfer_state_t      state_r;
  xfer_state_t      state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [SC_W-1:0]  rise_cnt_r;
  logic [SC_W-1:0]  scnt_r;
  logic [WORD_W-1:0] tx_shift_r;
  logic [WORD_W-1:0] rx_shift_r;
  logic             s_ph_q_r;

  logic             fifo_valid_w;
  logic [WORD_W-1:0] fifo_data_w;
  logic             sel_w;
  logic             rx_act_w;
  logic             s_ph_w;
  logic             start_m_w;
  logic             start_s_w;
  logic             pop_w;
  logic [WORD_W-1:0] load_w;
  logic             m_rise_w;
  logic             m_fall_w;
  logic             last_rise_w;
  logic             rise_ev_w;
  logic             fall_ev_w;
  logic             sample_ev_w;
  logic             change_ev_w;
  logic             do_sample_w;
  logic             do_shift_w;
  logic             release_w;
  logic             frame_act_nxt;
  logic             ph_nxt;

  assign sel_w    = tx_frame_pin_in ^ cfg.tx_frame_polarity;
  assign rx_act_w = rx_frame_pin_in ^ cfg.rx_frame_polarity;
  assign s_ph_w   = tx_serial_clock_pin_in ~^ cfg.tx_clock_polarity;

  assign start_m_w = (state_r == ST_IDLE) && master_w && stop_on_w
                     && fifo_valid_w;
  assign start_s_w = (state_r == ST_IDLE) && slave_w && stop_on_w && sel_w;
  assign pop_w     = start_m_w || (start_s_w && fifo_valid_w);
  assign load_w    = fifo_valid_w ? fifo_data_w : '0;

  assign m_rise_w    = (state_r == ST_LOW) && (cnt_r == '0);
  assign m_fall_w    = ((state_r == ST_LEAD) || (state_r == ST_HIGH))
                       && (cnt_r == '0);
  assign last_rise_w = m_rise_w && (rise_cnt_r == BITS_LAST);

  assign rise_ev_w = master_w ? m_rise_w
                   : ((state_r == ST_SLAVE) && s_ph_w && !s_ph_q_r);
  assign fall_ev_w = master_w ? m_fall_w
                   : ((state_r == ST_SLAVE) && !s_ph_w && s_ph_q_r);
  // sample and change edges by clock stop mode
  assign sample_ev_w = mode_fall_w ? fall_ev_w : rise_ev_w;
  assign change_ev_w = mode_fall_w ? rise_ev_w : fall_ev_w;
  assign do_sample_w = sample_ev_w && (master_w || rx_act_w)
                       && (scnt_r != BITS_N);
  assign do_shift_w  = change_ev_w && (scnt_r != '0) && (scnt_r != BITS_N);

  // data release one high phase after the last rising edge
  assign release_w = (state_r == ST_LAG) && (cnt_r == CNT_W'(lag_w - hi_w));

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = (cnt_r == '0) ? cnt_r : CNT_W'(cnt_r - 1'h1);
    unique case (state_r)
      ST_IDLE: begin
        if (start_m_w) begin
          state_nxt = ST_LEAD;
          cnt_nxt   = CNT_W'(lead_w - 1'h1);
        end else if (start_s_w) begin
          state_nxt = ST_SLAVE;
        end
      end
      ST_LEAD, ST_HIGH: begin
        if (cnt_r == '0) begin
          state_nxt = ST_LOW;
          cnt_nxt   = CNT_W'(lo_w - 1'h1);
        end
      end
      ST_LOW: begin
        if (last_rise_w) begin
          state_nxt = ST_LAG;
          cnt_nxt   = CNT_W'(lag_w - 1'h1);
        end else if (cnt_r == '0) begin
          state_nxt = ST_HIGH;
          cnt_nxt   = CNT_W'(hi_w - 1'h1);
        end
      end
      ST_LAG: begin
        if (cnt_r == '0) state_nxt = ST_IDLE;
      end
      ST_SLAVE: begin
        if (!sel_w) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  assign frame_act_nxt = (state_nxt == ST_LEAD) || (state_nxt == ST_LOW)
                         || (state_nxt == ST_HIGH) || (state_nxt == ST_LAG);
  assign ph_nxt        = (state_nxt != ST_LOW);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      cnt_r      <= '0;
      rise_cnt_r <= '0;
      s_ph_q_r   <= PIN_IDLE_RST;
    end else if (ce) begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      s_ph_q_r   <= s_ph_w;
      if (start_m_w) rise_cnt_r <= '0;
      else if (m_rise_w) rise_cnt_r <= SC_W'(rise_cnt_r + 1'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_serial_clock_pin_out <= PIN_IDLE_RST;
      tx_serial_clock_pin_oe  <= 1'h0;
      tx_frame_pin_out        <= PIN_IDLE_RST;
      tx_frame_pin_oe         <= 1'h0;
    end else if (ce) begin
      tx_serial_clock_pin_out <= ph_nxt ~^ cfg.tx_clock_polarity;
      tx_serial_clock_pin_oe  <= master_w;
      // internal frame inverted onto the pin
      tx_frame_pin_out        <= frame_act_nxt ^ cfg.tx_frame_polarity;
      tx_frame_pin_oe         <= master_w;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_shift_r      <= '0;
      tx_data_pin_out <= DATA_OUT_RST;
      tx_data_pin_oe  <= 1'h0;
    end else if (ce) begin
      if (start_m_w || start_s_w) begin
        // first bit out before any clock edge
        tx_shift_r      <= load_w;
        tx_data_pin_out <= load_w[WORD_W-1];
        tx_data_pin_oe  <= 1'h1;
      end else if (do_shift_w) begin
        tx_shift_r      <= {tx_shift_r[WORD_W-2:0], 1'h0};
        tx_data_pin_out <= tx_shift_r[WORD_W-2];
      end
      // slave releases the data pin with the enable
      if ((state_r == ST_SLAVE && !sel_w) || release_w) begin
        tx_data_pin_oe <= 1'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive and status

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_shift_r    <= '0;
      scnt_r        <= '0;
      rx_word_data  <= '0;
      rx_word_valid <= 1'h0;
      busy          <= 1'h0;
      cfg_error     <= 1'h0;
    end else if (ce) begin
      rx_word_valid <= 1'h0;
      if (start_m_w || start_s_w) begin
        scnt_r <= '0;
      end else if (do_sample_w) begin
        rx_shift_r <= {rx_shift_r[WORD_W-2:0], rx_data_pin};
        scnt_r     <= SC_W'(scnt_r + 1'h1);
        if (scnt_r == BITS_LAST) begin
          rx_word_data  <= {rx_shift_r[WORD_W-2:0], rx_data_pin};
          rx_word_valid <= 1'h1;
        end
      end
      busy      <= (state_nxt != ST_IDLE);
      // flag settings unfit for this mode
      cfg_error <= !(master_w || slave_w) || !cfg.tx_frame_polarity
                   || !cfg.rx_frame_polarity
                   || (slave_w && (!cfg.gen_clock_source_select
                   || cfg.clock_divide_value != SLAVE_DIV_VALUE));
    end
  end

  word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_data   (tx_word_data),
    .in_valid  (tx_word_valid),
    .in_ready  (tx_word_ready),
    .out_data  (fifo_data_w),
    .out_valid (fifo_valid_w),
    .out_ready (pop_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic             sclk_q_r;
  logic             frame_q_r;
  logic [CNT_W-1:0] run_r;
  logic [CNT_W-1:0] frun_r;
  logic [CNT_W-1:0] hi_seen_r;
  logic             chk_w;
  logic             pin_rose_w;
  logic             pin_fell_w;

  assign chk_w      = ce && master_w && cfg.tx_clock_polarity
                      && cfg.tx_frame_polarity;
  assign pin_rose_w = tx_serial_clock_pin_out && !sclk_q_r;
  assign pin_fell_w = !tx_serial_clock_pin_out && sclk_q_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q_r  <= PIN_IDLE_RST;
      frame_q_r <= PIN_IDLE_RST;
      run_r     <= '0;
      frun_r    <= '0;
      hi_seen_r <= '0;
    end else if (ce) begin
      sclk_q_r  <= tx_serial_clock_pin_out;
      frame_q_r <= tx_frame_pin_out;
      if (tx_serial_clock_pin_out != sclk_q_r) run_r <= CNT_W'(1);
      else if (run_r != '1) run_r <= CNT_W'(run_r + 1'h1);
      if (tx_frame_pin_out != frame_q_r) frun_r <= CNT_W'(1);
      else if (frun_r != '1) frun_r <= CNT_W'(frun_r + 1'h1);
      if (pin_fell_w) hi_seen_r <= run_r;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence rise_seen_s;
    chk_w && pin_rose_w;
  endsequence

  sequence fall_seen_s;
    chk_w && pin_fell_w;
  endsequence

  low_phase_len_a: assert property (
    rise_seen_s |-> run_r == lo_w)
    else $error("serial clock low phase has wrong length");

  high_phase_len_a: assert property (
    fall_seen_s and (rise_cnt_r != '0) |-> run_r == hi_w)
    else $error("serial clock high phase has wrong length");

  clock_period_a: assert property (
    rise_seen_s and (rise_cnt_r > SC_W'(1))
    |-> CNT_W'(run_r + hi_seen_r) == per_w)
    else $error("serial clock period has wrong length");

  enable_active_low_a: assert property (
    chk_w && state_r inside {ST_LEAD, ST_LOW, ST_HIGH, ST_LAG}
    |-> !tx_frame_pin_out && tx_frame_pin_oe)
    else $error("slave enable not low during transfer");

  enable_lead_a: assert property (
    fall_seen_s and (rise_cnt_r == '0) |-> frun_r == lead_w)
    else $error("slave enable lead before first edge is wrong");

  enable_lag_a: assert property (
    chk_w && tx_frame_pin_out && !frame_q_r |-> run_r == lag_w)
    else $error("slave enable lag after last edge is wrong");

  data_release_a: assert property (
    chk_w && !mode_fall_w && $fell(tx_data_pin_oe) |-> run_r == hi_w)
    else $error("data pin released at wrong time");

  rise_sample_a: assert property (
    rise_seen_s and !mode_fall_w |-> scnt_r == rise_cnt_r)
    else $error("receive bit not taken on rising edge");

  fall_sample_a: assert property (
    fall_seen_s and mode_fall_w
    |-> scnt_r == SC_W'(rise_cnt_r + 1'h1))
    else $error("receive bit not taken on falling edge");

  slave_enable_a: assert property (
    ce && slave_w && stop_on_w && state_r == ST_IDLE
    && tx_frame_pin_in == !cfg.tx_frame_polarity
    |=> state_r == ST_SLAVE ##0 tx_data_pin_oe)
    else $error("slave did not open on inverted enable");

  slave_first_bit_a: assert property (
    ce && start_s_w |=> tx_data_pin_oe
    && tx_data_pin_out == tx_shift_r[WORD_W-1])
    else $error("slave first bit not driven on enable");

  slave_hiz_a: assert property (
    ce && state_r == ST_SLAVE && !sel_w |=> !tx_data_pin_oe)
    else $error("slave data pin not released");

endmodule : spi_clock_stop_port

// File: tb/spi_slave_model.sv
`timescale 1ns/1ns
module spi_slave_model
  import spi_port_pkg::*;
(
  input  wire logic        sck,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] tx_word,
  output logic             miso,
  output logic [15:0]      rx_word
);
  logic [15:0] sh_r;
  int          n_bits;

  initial begin
    miso = 1'h0;
    rx_word = 16'h0000;
    n_bits = 0;
  end

  task automatic take();
    rx_word = {rx_word[14:0], mosi};
    n_bits++;
  endtask : take

  // the change edge ahead of the first sample is skipped
  task automatic shift();
    if (n_bits > 0 && n_bits < 16) begin
      sh_r = sh_r << 1;
      miso = sh_r[15];
    end
  endtask : shift

  always @(negedge sel_n) begin
    sh_r = tx_word;
    n_bits = 0;
    miso = sh_r[15];
  end

  // released line shows the inverse of its last bit
  always @(posedge sel_n) miso = ~miso;

  always @(posedge sck) begin
    if (sel_n === 1'h0) begin
      if (mode == STOP_SAMPLE_RISE) take();
      else shift();
    end
  end

  always @(negedge sck) begin
    if (sel_n === 1'h0) begin
      if (mode == STOP_SAMPLE_RISE) shift();
      else take();
    end
  end
endmodule : spi_slave_model

// File: tb/test_serial_port_clock_stop_spi.sv
`timescale 1ns/1ns
module test_serial_port_clock_stop_spi;
  import spi_port_pkg::*;
  logic        clk, rst, ce, tx_word_valid, tx_word_ready, rx_word_valid;
  port_cfg_t   cfg;
  logic [15:0] tx_word_data, rx_word_data, p_tx, p_rx, got_rx;
  logic        sck_out, sck_oe, fs_out, fs_oe, data_out, data_oe;
  logic        busy, cfg_error, p_miso, tb_sck, tb_fs, tb_mosi, slave_mode;
  wire logic   sck_w = sck_oe ? sck_out : tb_sck;
  wire logic   fs_w  = fs_oe ? fs_out : tb_fs;
  wire logic   mosi_w = data_oe ? data_out : ~data_out;
  wire logic   rx_w  = slave_mode ? tb_mosi : p_miso;
  int          n_errors, n_compared, n_rx, cyc;
  logic [15:0] p_q[$];

  spi_clock_stop_port u_spi_clock_stop_port (
    .clk(clk), .rst(rst), .ce(ce), .cfg(cfg),
    .tx_word_data(tx_word_data), .tx_word_valid(tx_word_valid),
    .tx_word_ready(tx_word_ready), .rx_word_data(rx_word_data),
    .rx_word_valid(rx_word_valid), .tx_serial_clock_pin_in(sck_w),
    .tx_serial_clock_pin_out(sck_out), .tx_serial_clock_pin_oe(sck_oe),
    .tx_frame_pin_in(fs_w), .tx_frame_pin_out(fs_out),
    .tx_frame_pin_oe(fs_oe), .rx_frame_pin_in(fs_w),
    .tx_data_pin_out(data_out), .tx_data_pin_oe(data_oe),
    .rx_data_pin(rx_w), .busy(busy), .cfg_error(cfg_error));

  spi_slave_model u_spi_slave_model (
    .sck(sck_w), .sel_n(slave_mode | fs_w), .mosi(mosi_w),
    .mode(cfg.clock_stop_select), .tx_word(p_tx), .miso(p_miso),
    .rx_word(p_rx));

  initial begin
    clk = 1'h0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rx_word_valid === 1'h1) begin
      got_rx <= rx_word_data;
      n_rx <= n_rx + 1;
    end
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end

  always @(posedge fs_w) if (slave_mode === 1'h0) p_q.push_back(p_rx);

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic port_cfg_t mk_cfg(logic [1:0] m, logic s, logic [7:0] d);
    port_cfg_t c;
    c = '0;
    c.clock_stop_select = m;
    c.tx_clock_polarity = 1'h1;
    c.tx_clock_direction = ~s;
    c.tx_frame_direction = ~s;
    c.tx_frame_polarity = 1'h1;
    c.rx_frame_polarity = 1'h1;
    c.gen_clock_source_select = 1'h1;
    c.clock_divide_value = d;
    return c;
  endfunction : mk_cfg

  task automatic push(input logic [15:0] w);
    tx_word_data <= w;
    tx_word_valid <= 1'h1;
    do @(posedge clk); while (tx_word_ready !== 1'h1);
  endtask : push

  task automatic master_xfer(input logic [1:0] m, input logic [7:0] d,
                             input logic [15:0] w, pw);
    int lo, hi, lead, oe_n, n0;
    logic [7:0] l_e, h_e;
    l_e = d[0] ? 8'((d + 1) >> 1) : (d == 8'h00) ? 8'h01 : 8'(d >> 1);
    h_e = (d[0] || d == 8'h00) ? l_e : l_e + 8'h01;
    n0 = n_rx;
    @(posedge clk);
    p_tx <= pw;
    cfg <= mk_cfg(m, 1'h0, d);
    @(posedge clk);
    push(w);
    tx_word_valid <= 1'h0;
    @(negedge clk);
    while (fs_w !== 1'h0) @(negedge clk);
    check("clock oe", sck_oe, 1);
    check("frame oe", fs_oe, 1);
    lead = 0;
    while (sck_w === 1'h1) begin
      lead++;
      @(negedge clk);
    end
    check("lead", lead, m == STOP_SAMPLE_RISE ? h_e : h_e + l_e);
    for (int b = 0; b < 16; b++) begin
      lo = 0;
      hi = 0;
      oe_n = 0;
      while (sck_w === 1'h0) begin
        lo++;
        @(negedge clk);
      end
      while (sck_w === 1'h1 && (b < 15 || fs_w === 1'h0)) begin
        hi++;
        oe_n += (data_oe === 1'h1);
        @(negedge clk);
      end
      check("low", lo, l_e);
      if (b < 15) check("high", hi, h_e);
    end
    check("lag", hi, m == STOP_SAMPLE_RISE ? h_e + l_e : h_e);
    check("data hold", oe_n, h_e);
    @(negedge clk);
    check("rx count", n_rx - n0, 1);
    check("rx word", got_rx, pw);
    check("wire word", p_rx, w);
  endtask : master_xfer

  task automatic t_reset();
    check("clock pin", sck_out, 1);
    check("frame pin", fs_out, 1);
    check("oe", {sck_oe, fs_oe, data_oe, busy, cfg_error}, 0);
    check("ready", tx_word_ready, 0);
    @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(negedge clk);
    check("ready", tx_word_ready, 1);
  endtask : t_reset

  task automatic t_master();
    master_xfer(2'h2, 8'h01, 16'hA5C3, 16'h3C5A);
    master_xfer(2'h3, 8'h02, 16'h8001, 16'h7FFE);
    master_xfer(2'h2, 8'h04, 16'h1234, 16'hFEDC);
    master_xfer(2'h3, 8'h00, 16'h0F0F, 16'hC001);
    master_xfer(2'h3, 8'h03, 16'h6B29, 16'h94D6);
  endtask : t_master

  task automatic t_fifo();
    p_q.delete();
    @(posedge clk);
    cfg <= mk_cfg(2'h0, 1'h0, 8'h01);
    @(posedge clk);
    for (int i = 0; i < 8; i++) push(16'(16'h8001 + i * 16'h1111));
    tx_word_data <= 16'hDEAD;
    repeat (4) @(posedge clk);
    tx_word_valid <= 1'h0;
    check("full", tx_word_ready, 0);
    check("idle", busy, 0);
    cfg <= mk_cfg(2'h2, 1'h0, 8'h01);
    for (int i = 0; i < 1000 && p_q.size() < 8; i++) @(negedge clk);
    repeat (60) @(negedge clk);
    check("frames", p_q.size(), 8);
    for (int i = 0; i < 8 && i < p_q.size(); i++)
      check("order", p_q[i], 16'(16'h8001 + i * 16'h1111));
    check("drained", {tx_word_ready, busy}, 2'h2);
  endtask : t_fifo

  task automatic t_slave(input logic [15:0] w, rw);
    @(posedge clk);
    cfg <= mk_cfg(2'h2, 1'h1, 8'h01);
    slave_mode <= 1'h1;
    @(posedge clk);
    push(w);
    tx_word_valid <= 1'h0;
    tb_fs <= 1'h0;
    repeat (3) @(posedge clk);
    check("clock in", sck_oe, 0);
    check("cfg ok", cfg_error, 0);
    check("first oe", data_oe, 1);
    for (int b = 0; b < 16; b++) begin
      tb_sck <= 1'h0;
      tb_mosi <= rw[15 - b];
      repeat (4) @(posedge clk);
      check("slave bit", data_out, w[15 - b]);
      tb_sck <= 1'h1;
      repeat (4) @(posedge clk);
    end
    tb_fs <= 1'h1;
    repeat (3) @(posedge clk);
    check("slave rx", got_rx, rw);
    check("slave off", {data_oe, busy}, 0);
    cfg <= mk_cfg(2'h2, 1'h1, 8'h02);
    repeat (3) @(posedge clk);
    check("cfg bad", cfg_error, 1);
    slave_mode <= 1'h0;
  endtask : t_slave

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  initial begin
    {rst, ce, tb_sck, tb_fs} = 4'hF;
    {tx_word_valid, tb_mosi, slave_mode} = 3'h0;
    n_errors = 0;
    n_compared = 0;
    n_rx = 0;
    cyc = 0;
    tx_word_data = 16'h0000;
    p_tx = 16'h0000;
    got_rx = 16'h0000;
    cfg = mk_cfg(2'h0, 1'h0, 8'h01);
    repeat (3) @(negedge clk);
    t_reset();
    t_master();
    t_fifo();
    t_slave(16'hC3A5, 16'h5AB7);
    conclude();
  end
endmodule : test_serial_port_clock_stop_spi
